//--- hdl/nud_defines.svh
// Constants of the noise update decision block: offsets, resets, limits.
// Assumes the fixed-point formats listed below are used by the feature
// extractors that feed the block.
//
// Behaviour
// - Hangover starts at 6; active frame adds 2, inactive subtracts 1.
// - Hangover saturates between 0 and 6 after every step.
// - Limits: wideband 350000/0.85/1.6, narrowband 500000/0.7/10.4.
// - Without any increment condition the hangover drops by 1.
// - Noise energy update is permitted only while hangover equals 0.
// - Below 100 init frames closeness compares against constant 0.0035.
// - Closeness sums |log(avg energy+1) - log(noise+1)| over bands 2..16.
// - Closeness band range does not depend on bandwidth.
// - Harmonic counter clears on correlation mean above 0.85 or tonal.
// - Counter above 1 clamps to 1 on low energy or energy jump.
// - Counter above 1 quartered (min 1) on loud, varying frames.
// - Event average moves to 1 or 0 with coefficient 0.03 or 0.01.
// - Pause counter starts at 0; energy rise above 5 sets minus one.
// - At minus one, energy back below 5 sets the counter to 0.
// - Last step adds one to a non-negative pause counter.
// - Tonal flag is map sum above threshold or strong peak.
`ifndef NUD_DEFINES_SVH
`define NUD_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define NUD_OFS_CTRL     8'h00
`define NUD_OFS_STATUS   8'h04
`define NUD_OFS_HARM     8'h08
`define NUD_OFS_PAUSE    8'h0C
`define NUD_OFS_EVENT    8'h10
`define NUD_OFS_CLOSE    8'h14
`define NUD_CTRL_WB_BIT  0
`define NUD_CTRL_RESET   1'h1

// ---------------------------------------------------------------------------
// State bounds and reset values
// ---------------------------------------------------------------------------
`define NUD_HANG_INIT    3'h6
`define NUD_HANG_MAX     3'h6
`define NUD_HANG_UP      3'h2
`define NUD_PAUSE_INIT   16'sh0000
`define NUD_PAUSE_ACTIVE (-16'sh0001)
`define NUD_PAUSE_MAX    16'sh7FFF
`define NUD_BAND_FIRST   5'h02
`define NUD_BAND_LAST    5'h10

// ---------------------------------------------------------------------------
// Limits (nonstat integer, correlation Q1.15, residual and energy Q8.8)
// ---------------------------------------------------------------------------
`define NUD_STA_WB       32'h0005_5730
`define NUD_STA_NB       32'h0007_A120
`define NUD_CORR_WB      17'h0_6CCD
`define NUD_CORR_NB      17'h0_599A
`define NUD_RESID_WB     16'h019A
`define NUD_RESID_NB     16'h0A66
`define NUD_HARM_CORR    17'h0_6CCD
`define NUD_INIT_FRAMES  8'h64
`define NUD_INIT_JUMP    8'h0A
`define NUD_E_LOW        17'sh0_0F00
`define NUD_E_JUMP       17'sh0_0700
`define NUD_E_LOUD       17'sh0_1E00
`define NUD_E_VAR        16'sh0800
`define NUD_E_PAUSE      17'sh0_0500
`define NUD_E_MIN        32'h0000_00E5
`define NUD_LOG_ONE      33'h0_0001_0000
`define NUD_EV_FAST      12'h7AE
`define NUD_EV_SLOW      12'h28F
`define NUD_EV_FULL      16'hFFFF

`endif

//--- hdl/nud_pkg.sv
// Types shared by the noise update decision block.
// Assumes nud_defines.svh is compiled alongside.
`default_nettype none

package nud_pkg;

	typedef enum logic [1:0] {NUD_IDLE, NUD_ACCUM, NUD_DRAIN} nud_phase_t;

	typedef logic [16:0][31:0] nud_bandvec_t;

	typedef struct packed {
		nud_bandvec_t energy0;
		nud_bandvec_t energy1;
		nud_bandvec_t noise;
	} nud_bands_t;

	typedef struct packed {
		logic [31:0]        nonstat;
		logic [15:0]        corr0;
		logic [15:0]        corr1;
		logic [15:0]        residual;
		logic signed [15:0] frame_energy;
		logic signed [15:0] longterm_energy;
		logic signed [15:0] min_energy;
		logic signed [15:0] energy_var;
		logic [15:0]        corr_map_sum;
		logic [15:0]        tonal_threshold;
		logic               strong_peak;
		logic               extra_active;
		logic [7:0]         init_frames;
	} nud_frame_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} nud_bus_t;

endpackage

`default_nettype wire

//--- hdl/nud_log2.sv
// Registered base-2 logarithm of an unsigned value that is at least one.
// Input is Q17.16 and at least 1.0; output is Q6.10 with one cycle latency.
`include "nud_defines.svh"
`default_nettype none

module nud_log2
	import nud_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Operand and result
	input  wire logic [32:0] x,
	output logic      [15:0] y_q
);

	typedef struct packed {
		logic [15:0] y;
	} nud_log_state_t;

	nud_log_state_t s_q;
	nud_log_state_t s_d;

	// ---------------------------------------------------------------------
	// Leading one gives the exponent, the next ten bits the linear fraction.
	// ---------------------------------------------------------------------
	function automatic logic [15:0] nud_log2_q(input logic [32:0] v);
		logic [5:0]  p;
		logic [32:0] n;
		p = 6'd16;
		for (int i = 16; i <= 32; i++) begin
			if (v[i]) begin
				p = 6'(i);
			end
		end
		n = v << (6'd32 - p);
		return {p - 6'd16, n[31:22]};
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.y = nud_log2_q(x);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign y_q = s_q.y;

endmodule

`default_nettype wire

//--- hdl/nud_top.sv
// Per-frame noise update decision: hangover, closeness, harmonic event
// tracking and energy pause detection, with a small register port.
// Assumes frame inputs are synchronous to clk and band vectors hold still
// from an accepted frame strobe until frame_done_q.
`include "nud_defines.svh"
`default_nettype none

module nud_top
	import nud_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// Register port
	input  wire nud_bus_t           bus,
	output logic        [31:0]      rdata_q,
	// Frame inputs
	input  wire logic               frame_strobe,
	input  wire nud_frame_t         frame_in,
	input  wire nud_bands_t         bands_in,
	// Decisions
	output logic        [2:0]       hangover_q,
	output logic                    update_permitted_q,
	output logic                    tonal_q,
	output logic        [15:0]      harm_count_q,
	output logic        [15:0]      event_occurrence_avg_q,
	output logic signed [15:0]      pause_frame_counter_q,
	output logic        [23:0]      closeness_q,
	output logic                    busy_q,
	output logic                    frame_done_q
);

	typedef struct packed {
		nud_phase_t         phase;
		logic [4:0]         idx;
		logic               pend;
		logic               init_phase;
		logic [23:0]        acc;
		logic [23:0]        close;
		logic [2:0]         hang;
		logic               upd;
		logic               tonal;
		logic [15:0]        harm;
		logic [15:0]        ev;
		logic signed [15:0] pause;
		logic               wideband;
		logic               done;
		logic               busy;
		logic [31:0]        rdata;
	} nud_state_t;

	nud_state_t s_q;
	nud_state_t s_d;

	logic               accept;
	logic [16:0]        corr_mean;
	logic               active;
	logic               tonal;
	logic               harm_event;
	logic signed [16:0] gap_min;
	logic signed [16:0] gap_lt;
	logic signed [16:0] energy;
	logic [15:0]        harm_n;
	logic signed [15:0] pause_n;
	logic [2:0]         hang_n;
	logic [32:0]        log_a_in;
	logic [32:0]        log_b_in;
	logic [15:0]        log_a;
	logic [15:0]        log_b;
	logic [15:0]        log_diff;
	logic [32:0]        band_sum;
	logic [31:0]        ref_val;

	// ---------------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------------
	// First-order recursion toward full scale on a hit, toward zero else.
	function automatic logic [15:0] nud_ev_step(input logic [15:0] avg,
	                                            input logic        hit);
		logic [16:0] span;
		logic [28:0] prod;
		span = hit ? 17'(`NUD_EV_FULL - avg) : {1'b0, avg};
		prod = span * (hit ? `NUD_EV_FAST : `NUD_EV_SLOW);
		return hit ? avg + 16'(prod[28:16]) : avg - 16'(prod[28:16]);
	endfunction

	function automatic logic signed [16:0] nud_sub(
		input logic signed [15:0] a,
		input logic signed [15:0] b);
		return 17'(a) - 17'(b);
	endfunction

	// ---------------------------------------------------------------------
	// Log units for the closeness measure
	// ---------------------------------------------------------------------
	// The averaged energy and the reference each get their own unit so that
	// one band finishes per cycle; that costs a second log unit.
	assign band_sum = 33'(bands_in.energy0[s_q.idx])
	                + 33'(bands_in.energy1[s_q.idx]);
	assign ref_val  = s_q.init_phase ? `NUD_E_MIN
	                                 : bands_in.noise[s_q.idx];
	assign log_a_in = (band_sum >> 1) + `NUD_LOG_ONE;
	assign log_b_in = 33'(ref_val) + `NUD_LOG_ONE;
	assign log_diff = (log_a > log_b) ? log_a - log_b : log_b - log_a;

	nud_log2 u_log_avg (
		.clk  (clk),
		.nrst (nrst),
		.x    (log_a_in),
		.y_q  (log_a)
	);

	nud_log2 u_log_ref (
		.clk  (clk),
		.nrst (nrst),
		.x    (log_b_in),
		.y_q  (log_b)
	);

	// ---------------------------------------------------------------------
	// Frame decisions
	// ---------------------------------------------------------------------
	always_comb begin
		accept    = frame_strobe && (s_q.phase == NUD_IDLE);
		corr_mean = (17'(frame_in.corr0) + 17'(frame_in.corr1)) >> 1;
		energy    = 17'(frame_in.frame_energy);
		gap_min   = nud_sub(frame_in.frame_energy, frame_in.min_energy);
		gap_lt    = nud_sub(frame_in.frame_energy, frame_in.longterm_energy);
		tonal     = (frame_in.corr_map_sum > frame_in.tonal_threshold)
		         || frame_in.strong_peak;
		harm_event = (corr_mean > `NUD_HARM_CORR) || tonal;
		// Bandwidth picks the limit set.
		if (s_q.wideband) begin
			active = (frame_in.nonstat > `NUD_STA_WB)
			      || (17'(frame_in.corr0) > `NUD_CORR_WB)
			      || (frame_in.residual > `NUD_RESID_WB);
		end else begin
			active = (frame_in.nonstat > `NUD_STA_NB)
			      || (17'(frame_in.corr0) > `NUD_CORR_NB)
			      || (frame_in.residual > `NUD_RESID_NB);
		end
		active = active || frame_in.extra_active;
		if (active) begin
			hang_n = (s_q.hang >= `NUD_HANG_MAX - `NUD_HANG_UP)
			       ? `NUD_HANG_MAX : s_q.hang + `NUD_HANG_UP;
		end else begin
			hang_n = (s_q.hang == 3'h0) ? 3'h0 : s_q.hang - 3'h1;
		end
		// Harmonic counter: reset or count, then clamp, then quarter.
		if (harm_event) begin
			harm_n = 16'h0000;
		end else if (s_q.harm == 16'hFFFF) begin
			harm_n = s_q.harm;
		end else begin
			harm_n = s_q.harm + 16'h0001;
		end
		if (harm_n > 16'h0001 && (energy < `NUD_E_LOW
		    || (frame_in.init_frames > `NUD_INIT_JUMP
		        && gap_lt > `NUD_E_JUMP))) begin
			harm_n = 16'h0001;
		end
		if (harm_n > 16'h0001 && energy > `NUD_E_LOUD
		    && frame_in.energy_var > `NUD_E_VAR) begin
			harm_n = (harm_n < 16'h0004) ? 16'h0001 : harm_n >> 2;
		end
		// Pause detector, each check seeing the previous result.
		pause_n = s_q.pause;
		if (pause_n >= 0 && gap_min > `NUD_E_PAUSE) begin
			pause_n = `NUD_PAUSE_ACTIVE;
		end
		if (pause_n == `NUD_PAUSE_ACTIVE && gap_min < `NUD_E_PAUSE) begin
			pause_n = `NUD_PAUSE_INIT;
		end
		if (pause_n >= 0 && pause_n != `NUD_PAUSE_MAX) begin
			pause_n = pause_n + 16'sh0001;
		end
	end

	// ---------------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done  = 1'b0;
		s_d.rdata = 32'h0000_0000;
		// Register port; reads answer in the next cycle only.
		if (bus.wr && bus.addr == `NUD_OFS_CTRL) begin
			s_d.wideband = bus.wdata[`NUD_CTRL_WB_BIT];
		end
		if (bus.rd) begin
			unique case (bus.addr)
				`NUD_OFS_CTRL: begin
					s_d.rdata = {31'h0, s_q.wideband};
				end
				`NUD_OFS_STATUS: begin
					s_d.rdata = {26'h0, s_q.phase != NUD_IDLE, s_q.tonal,
					             s_q.upd, s_q.hang};
				end
				`NUD_OFS_HARM: begin
					s_d.rdata = {16'h0, s_q.harm};
				end
				`NUD_OFS_PAUSE: begin
					s_d.rdata = {{16{s_q.pause[15]}}, s_q.pause};
				end
				`NUD_OFS_EVENT: begin
					s_d.rdata = {16'h0, s_q.ev};
				end
				`NUD_OFS_CLOSE: begin
					s_d.rdata = {8'h0, s_q.close};
				end
				default: begin
					s_d.rdata = 32'h0000_0000;
				end
			endcase
		end
		unique case (s_q.phase)
			NUD_IDLE: begin
				if (accept) begin
					s_d.hang  = hang_n;
					s_d.upd   = (hang_n == 3'h0);
					s_d.tonal = tonal;
					s_d.harm  = harm_n;
					s_d.ev    = nud_ev_step(s_q.ev, harm_n == 16'h0000);
					s_d.pause = pause_n;
					s_d.init_phase = frame_in.init_frames < `NUD_INIT_FRAMES;
					s_d.idx   = `NUD_BAND_FIRST;
					s_d.acc   = 24'h00_0000;
					s_d.pend  = 1'b0;
					s_d.phase = NUD_ACCUM;
				end
			end
			NUD_ACCUM: begin
				// Band idx enters the log units; the previous band leaves.
				s_d.acc  = s_q.acc + (s_q.pend ? 24'(log_diff) : 24'h00_0000);
				s_d.pend = 1'b1;
				// The index stops at the last band so it never leaves the vector.
				if (s_q.idx == `NUD_BAND_LAST) begin
					s_d.phase = NUD_DRAIN;
				end else begin
					s_d.idx = s_q.idx + 5'h01;
				end
			end
			NUD_DRAIN: begin
				s_d.close = s_q.acc + 24'(log_diff);
				s_d.pend  = 1'b0;
				s_d.done  = 1'b1;
				s_d.phase = NUD_IDLE;
			end
		endcase
		s_d.busy = (s_d.phase != NUD_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q            <= '0;
			s_q.phase      <= NUD_IDLE;
			s_q.hang       <= `NUD_HANG_INIT;
			s_q.pause      <= `NUD_PAUSE_INIT;
			s_q.wideband   <= `NUD_CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------------
	assign rdata_q                = s_q.rdata;
	assign hangover_q             = s_q.hang;
	assign update_permitted_q     = s_q.upd;
	assign tonal_q                = s_q.tonal;
	assign harm_count_q           = s_q.harm;
	assign event_occurrence_avg_q = s_q.ev;
	assign pause_frame_counter_q  = s_q.pause;
	assign closeness_q            = s_q.close;
	assign busy_q                 = s_q.busy;
	assign frame_done_q           = s_q.done;

	// ---------------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_take_active;
		accept && active;
	endsequence

	sequence s_take_quiet;
		accept && !active;
	endsequence

	sequence s_busy_run;
		busy_q [*8] ##1 busy_q [*8];
	endsequence

	a_hang_bound: assert property (hangover_q <= `NUD_HANG_MAX)
		else $error("hangover left its range");

	a_hang_rise: assert property (s_take_active |=>
		hangover_q == (($past(hangover_q) >= 3'h4) ? 3'h6
		               : $past(hangover_q) + 3'h2))
		else $error("hangover did not rise by two");

	a_hang_decay: assert property (s_take_quiet |=>
		hangover_q == (($past(hangover_q) == 3'h0) ? 3'h0
		               : $past(hangover_q) - 3'h1))
		else $error("hangover did not fall by one");

	a_update_flag: assert property (
		update_permitted_q == (hangover_q == 3'h0))
		else $error("update permission disagrees with hangover");

	a_hang_drain: assert property (s_take_quiet ##0 (hangover_q == 3'h6)
		|=> !update_permitted_q && hangover_q == 3'h5)
		else $error("update permitted at full hangover");

	a_harm_clear: assert property (accept && harm_event |=>
		harm_count_q == 16'h0000 && event_occurrence_avg_q
		>= $past(event_occurrence_avg_q))
		else $error("harmonic event not registered");

	a_harm_clamp: assert property (accept && !harm_event
		&& energy < `NUD_E_LOW |=> harm_count_q <= 16'h0001)
		else $error("harmonic counter not clamped");

	a_event_fall: assert property (accept && harm_n != 16'h0000
		|=> event_occurrence_avg_q <= $past(event_occurrence_avg_q))
		else $error("event average rose without event");

	a_pause_enter: assert property (accept && pause_frame_counter_q >= 0
		&& gap_min > `NUD_E_PAUSE |=>
		pause_frame_counter_q == `NUD_PAUSE_ACTIVE)
		else $error("pause counter did not go active");

	a_pause_leave: assert property (accept
		&& pause_frame_counter_q == `NUD_PAUSE_ACTIVE
		&& gap_min < `NUD_E_PAUSE |=> pause_frame_counter_q == 16'sh0001)
		else $error("pause counter did not restart at one");

	a_tonal_flag: assert property (accept |=>
		tonal_q == $past(tonal))
		else $error("tonal flag mismatch");

	a_frame_run: assert property (accept |=> s_busy_run ##1
		(frame_done_q && !busy_q))
		else $error("closeness pass length wrong");

	a_frame_once: assert property (!accept |=>
		$stable(hangover_q) && $stable(pause_frame_counter_q)
		&& $stable(harm_count_q))
		else $error("frame state moved without a frame");

endmodule

`default_nettype wire

//--- test/nud_feeder.sv
// Upstream feature source model for the noise update decision block.
// Assumes the bench pulses go for one cycle beside a stable frame_d.
`default_nettype none

module nud_feeder
	import nud_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Bench side
	input  wire logic       go,
	input  wire logic       eager,
	input  wire nud_frame_t frame_d,
	input  wire nud_bands_t bands_d,
	// Block side
	input  wire logic       busy_q,
	output logic            frame_strobe,
	output var nud_frame_t  frame_in,
	output var nud_bands_t  bands_in
);
	timeunit 1ns;
	timeprecision 1ps;

	nud_frame_t f_q;
	logic       eager_q;

	// -------------------------------------------------------------------
	// Frame presentation
	// -------------------------------------------------------------------
	// Fields are inverted outside the strobe so a stale frame never passes.
	assign frame_in = frame_strobe ? f_q : ~f_q;

	// An eager strobe lasts one cycle whatever busy says; it never touches
	// the bands, which must stay still under a frame in progress.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			frame_strobe <= 1'b0;
			eager_q <= 1'b0;
			f_q <= '0;
			bands_in <= '0;
		end else if (go) begin
			frame_strobe <= 1'b1;
			eager_q <= eager;
			f_q <= frame_d;
			if (!eager)
				bands_in <= bands_d;
		end else if (frame_strobe && (!busy_q || eager_q)) begin
			frame_strobe <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- test/noise_update_decision_tb.sv
// Self-checking bench for the noise update decision block.
// Assumes nud_top and the feeder model; expected state comes from the
// bench's own models of the hangover, harmonic and pause counters.
`include "nud_defines.svh"
`default_nettype none

module noise_update_decision_tb
	import nud_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clk;
	logic               nrst;
	nud_bus_t           bus;
	logic        [31:0] rdata_q;
	logic               frame_strobe, go, eager;
	nud_frame_t         frame_in, fr;
	nud_bands_t         bands_in, bd;
	logic        [2:0]  hangover_q;
	logic               update_permitted_q, tonal_q, busy_q, frame_done_q;
	logic        [15:0] harm_count_q, event_occurrence_avg_q;
	logic signed [15:0] pause_frame_counter_q;
	logic        [23:0] closeness_q;
	int                 n_errors, n_compared, cycles;
	int                 m_hang, m_harm, m_pause, wb;

	nud_top nud_top_inst (.clk, .nrst, .bus, .rdata_q, .frame_strobe,
		.frame_in, .bands_in, .hangover_q, .update_permitted_q, .tonal_q,
		.harm_count_q, .event_occurrence_avg_q, .pause_frame_counter_q,
		.closeness_q, .busy_q, .frame_done_q);
	nud_feeder nud_feeder_inst (.clk, .nrst, .go, .eager, .frame_d(fr),
		.bands_d(bd), .busy_q, .frame_strobe, .frame_in, .bands_in);

	// -------------------------------------------------------------------
	// Reference models and helpers
	// -------------------------------------------------------------------
	function automatic int x_hang(input int h, input nud_frame_t f);
		if (f.nonstat > (wb ? `NUD_STA_WB : `NUD_STA_NB)
			|| f.corr0 > (wb ? `NUD_CORR_WB : `NUD_CORR_NB)
			|| f.residual > (wb ? `NUD_RESID_WB : `NUD_RESID_NB)
			|| f.extra_active)
			return h > 4 ? 6 : h + 2;
		return h > 0 ? h - 1 : 0;
	endfunction

	function automatic int x_harm(input int h, input nud_frame_t f,
		input logic tn);
		int e;
		e = int'(f.frame_energy);
		if ((int'(f.corr0) + int'(f.corr1)) / 2 > int'(`NUD_HARM_CORR) || tn)
			h = 0;
		else if (h < 65535)
			h++;
		if (h > 1 && (e < int'(`NUD_E_LOW) || (f.init_frames > `NUD_INIT_JUMP
			&& e - int'(f.longterm_energy) > int'(`NUD_E_JUMP))))
			h = 1;
		if (h > 1 && e > int'(`NUD_E_LOUD)
			&& int'(f.energy_var) > int'(`NUD_E_VAR))
			h = h < 4 ? 1 : h / 4;
		return h;
	endfunction

	function automatic int x_pause(input int p, input nud_frame_t f);
		int g;
		g = int'(f.frame_energy) - int'(f.min_energy);
		if (p >= 0 && g > int'(`NUD_E_PAUSE))
			p = -1;
		if (p == -1 && g < int'(`NUD_E_PAUSE))
			p = 0;
		if (p >= 0 && p < 32767)
			p++;
		return p;
	endfunction

	function automatic nud_bands_t mk_bands(input logic [31:0] e, n, lo);
		nud_bands_t b;
		for (int i = 0; i < 17; i++) begin
			b.energy0[i] = i < 2 ? lo : e;
			b.energy1[i] = i < 2 ? lo : e;
			b.noise[i] = n;
		end
		return b;
	endfunction

	// Half the frames are made quiet so the hangover can reach zero.
	function automatic nud_frame_t rnd_frame();
		nud_frame_t f;
		f.nonstat = $urandom & 32'h0007_FFFF;
		{f.corr0, f.corr1} = $urandom & 32'h7FFF_7FFF;
		{f.frame_energy, f.min_energy} = $urandom & 32'h3FFF_3FFF;
		{f.longterm_energy, f.energy_var} = $urandom & 32'h3FFF_0FFF;
		{f.corr_map_sum, f.tonal_threshold} = $urandom & 32'h00FF_00FF;
		f.residual = 16'($urandom & 32'h0000_0FFF);
		f.init_frames = 8'($urandom);
		f.strong_peak = ($urandom & 7) == 0;
		f.extra_active = ($urandom & 7) == 0;
		if ($urandom & 1) begin
			f.nonstat = f.nonstat >> 4;
			f.corr0 = f.corr0 >> 2;
			f.residual = f.residual >> 4;
			f.extra_active = 1'b0;
		end
		return f;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("compared=%0d errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata_q, e);
	endtask

	task automatic reset_dut();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(hangover_q, 6);
		chk(update_permitted_q, 0);
		chk(harm_count_q, 0);
		chk(event_occurrence_avg_q, 0);
		chk(32'(pause_frame_counter_q), 0);
		chk(busy_q | frame_done_q, 0);
		@(posedge clk);
		nrst <= 1'b1;
		m_hang = 6;
		m_harm = 0;
		m_pause = 0;
		wb = 1;
	endtask

	// A poked frame fires a second strobe while busy, carrying an active
	// frame; the block must ignore it entirely.
	task automatic run_frame(input nud_frame_t f, input nud_bands_t b,
		input int cl, input bit poke);
		logic [15:0] pa;
		logic        tn;
		bit          ok;
		pa = event_occurrence_avg_q;
		tn = f.corr_map_sum > f.tonal_threshold || f.strong_peak;
		m_hang = x_hang(m_hang, f);
		m_harm = x_harm(m_harm, f, tn);
		m_pause = x_pause(m_pause, f);
		@(posedge clk);
		fr <= f;
		bd <= b;
		go <= 1'b1;
		eager <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			go <= poke && i == 4;
			eager <= poke;
			fr.extra_active <= 1'b1;
			#1;
			if (frame_done_q === 1'b1)
				break;
		end
		ok = m_harm == 0 ? event_occurrence_avg_q > pa || pa > 16'hFF00
			: event_occurrence_avg_q < pa || pa < 16'h0100;
		chk(frame_done_q, 1'b1);
		chk(hangover_q, m_hang);
		chk(update_permitted_q, m_hang == 0);
		chk(tonal_q, tn);
		chk(harm_count_q, m_harm);
		chk(32'(pause_frame_counter_q), 32'(m_pause));
		chk(ok, 1'b1);
		if (cl >= 0)
			chk(closeness_q, cl);
		if (cl == -2)
			chk(closeness_q != 0, 1'b1);
	endtask

	// -------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// -------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// The whole run needs about 5400 cycles; the ceiling leaves margin.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			stop_test();
		end
	end

	initial begin
		nud_frame_t  f;
		logic [15:0] gap [6];
		logic [31:0] lim [2][3];
		logic [31:0] v;
		nrst = 1'b0;
		bus = '0;
		go = 1'b0;
		eager = 1'b0;
		fr = '0;
		bd = '0;
		gap = '{16'h0500, 16'h0501, 16'h0500, 16'h04FF, 16'h0000, 16'h0501};
		lim = '{'{`NUD_STA_NB, `NUD_CORR_NB, `NUD_RESID_NB},
			'{`NUD_STA_WB, `NUD_CORR_WB, `NUD_RESID_WB}};
		void'($urandom(32'h0000_BEA1));
		reset_dut();
		bus_rd(`NUD_OFS_CTRL, 1);
		bus_rd(8'h18, 0);
		f = '0;
		for (int k = 0; k < 7; k++)
			run_frame(f, mk_bands(`NUD_E_MIN, $urandom, `NUD_E_MIN), 0,
				k == 3);
		f.init_frames = 8'h78;
		for (int w = 1; w >= 0; w--) begin
			wb = w;
			bus_wr(`NUD_OFS_CTRL, w);
			bus_rd(`NUD_OFS_CTRL, w);
			for (int k = 0; k < 9; k++) begin
				f.nonstat = 0;
				f.corr0 = 0;
				f.residual = 0;
				v = lim[k % 3 == 2 ? 1 - w : w][k / 3] + 32'(k % 3 != 0);
				case (k / 3)
					0: f.nonstat = v;
					1: f.corr0 = v[15:0];
					default: f.residual = v[15:0];
				endcase
				run_frame(f, mk_bands(32'h0002_0000, 32'h0002_0000,
					$urandom), 0, 0);
			end
		end
		f = '0;
		f.init_frames = 8'h78;
		run_frame(f, mk_bands(32'h0004_0000, 32'h0001_0000, 0), -2,
			0);
		bus_rd(`NUD_OFS_HARM, 32'(m_harm));
		for (int k = 0; k < 6; k++) begin
			f.min_energy = 16'h1000;
			f.frame_energy = 16'h1000 + gap[k];
			run_frame(f, bd, -1, 0);
		end
		bus_rd(`NUD_OFS_PAUSE, 32'(m_pause));
		bus_rd(`NUD_OFS_STATUS,
			{26'h0, 2'b00, m_hang == 0, 3'(m_hang)});
		for (int k = 0; k < 250; k++) begin
			if (k == 120)
				reset_dut();
			run_frame(rnd_frame(), mk_bands($urandom, $urandom, $urandom),
				-1, 0);
		end
		stop_test();
	end

endmodule

`default_nettype wire
